// *** bench/can_bus_node.sv ***
// Far-side CAN node model that drives the receive pin through a transceiver.
// Assumes the bench commands the bus level and clocks it from clk_sys.
module can_bus_node (
  input  wire logic clk_sys,
  input  wire logic drive_dominant,
  output logic      bus_receive_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Bus level
  // A released bus is pulled recessive, so it reads one and never holds a stale value.
  always @(negedge clk_sys) begin
    bus_receive_pin <= drive_dominant ? 1'b0 : 1'b1;
  end
endmodule : can_bus_node

// *** bench/tb.sv ***
// Self-checking bench for the bit-timing configuration block.
// Assumes one 100 MHz clock; inputs change on the falling edge.
`include "can_bit_timing_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys, resetn, config_mode, reg_wr, wake_in, drive_dominant;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic       bus_receive_pin, tq_tick_q, bit_start_q, sample_point_q;
  logic       rx_bit_q, wake_filter_en_q, wake_detect_q, seen;
  int         miscompares, compares;
  wire  [2:0] strobes = {sample_point_q, bit_start_q, tq_tick_q};
  can_bit_timing_config dut (.clk_sys(clk_sys), .resetn(resetn), .config_mode(config_mode),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_receive_pin(bus_receive_pin), .wake_in(wake_in), .tq_tick_q(tq_tick_q),
    .bit_start_q(bit_start_q), .sample_point_q(sample_point_q), .rx_bit_q(rx_bit_q),
    .wake_filter_en_q(wake_filter_en_q), .wake_detect_q(wake_detect_q));
  can_bus_node node (.clk_sys(clk_sys), .drive_dominant(drive_dominant),
    .bus_receive_pin(bus_receive_pin));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys) begin reg_addr = addr; reg_wdata = data; reg_wr = 1'b1; end
    @(negedge clk_sys) reg_wr = 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys) reg_addr = addr;
    @(negedge clk_sys) data = reg_rdata;
  endtask : read_reg
  // Counts falling edges until the chosen strobe is seen; the bound catches a dead engine.
  task automatic wait_pulse(input int idx, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (strobes[idx] !== 1'b1 && n < 2000);
    if (n >= 2000) check("strobe_timeout", 16'h0001, 16'h0000);
  endtask : wait_pulse
  task automatic measure_bit(input logic [7:0] qj, ss, pw, input logic lvl,
                             input int tq, bits, sp);
    int n, m;
    drive_dominant = ~lvl;
    write_reg(`QUANTUM_JUMP_CONFIG_ADDR, qj);
    write_reg(`SEGMENT_SAMPLING_CONFIG_ADDR, ss);
    write_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, pw);
    @(negedge clk_sys) config_mode = 1'b0;
    wait_pulse(0, n);
    wait_pulse(0, n);
    check("quantum_period", 16'(tq), 16'(n));
    wait_pulse(1, n);
    wait_pulse(2, n);
    check("sample_offset", 16'(sp), 16'(n));
    check("received_bit", {15'h0000, lvl}, {15'h0000, rx_bit_q});
    wait_pulse(1, m);
    check("bit_period", 16'(bits), 16'(n + m));
    @(negedge clk_sys) config_mode = 1'b1;
  endtask : measure_bit
  // ==========================================================================
  // Scenarios
  task automatic check_register_access;
    read_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, rd);
    check("wake_reset", {8'h00, `PHASE_TWO_WAKE_CONFIG_RST}, {8'h00, rd});
    read_reg(`SEGMENT_SAMPLING_CONFIG_ADDR, rd);
    check("segment_reset", {8'h00, `SEGMENT_SAMPLING_CONFIG_RST}, {8'h00, rd});
    read_reg(`QUANTUM_JUMP_CONFIG_ADDR, rd);
    check("quantum_reset", {8'h00, `QUANTUM_JUMP_CONFIG_RST}, {8'h00, rd});
    write_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, 8'hFF);
    write_reg(`SEGMENT_SAMPLING_CONFIG_ADDR, 8'hFF);
    write_reg(8'h30, 8'hFF);
    read_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, rd);
    check("wake_masked", 16'h0047, {8'h00, rd});
    read_reg(8'h30, rd);
    check("unmapped_read", 16'h0000, {8'h00, rd});
    config_mode = 1'b0;
    write_reg(`SEGMENT_SAMPLING_CONFIG_ADDR, 8'h5A);
    @(negedge clk_sys) config_mode = 1'b1;
    read_reg(`SEGMENT_SAMPLING_CONFIG_ADDR, rd);
    check("refused_write", 16'h00FF, {8'h00, rd});
  endtask : check_register_access
  task automatic check_wake_filter;
    write_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, 8'h40);
    repeat (2) @(negedge clk_sys);
    check("filter_on", 16'h0001, {15'h0000, wake_filter_en_q});
    seen = 1'b0;
    wake_in = 1'b0;
    repeat (3) @(negedge clk_sys) seen |= wake_detect_q;
    wake_in = 1'b1;
    repeat (4) @(negedge clk_sys) seen |= wake_detect_q;
    check("short_wake_filtered", 16'h0000, {15'h0000, seen});
    wake_in = 1'b0;
    repeat (12) @(negedge clk_sys) seen |= wake_detect_q;
    wake_in = 1'b1;
    check("long_wake_passed", 16'h0001, {15'h0000, seen});
    write_reg(`PHASE_TWO_WAKE_CONFIG_ADDR, 8'h00);
    repeat (2) @(negedge clk_sys);
    check("filter_off", 16'h0000, {15'h0000, wake_filter_en_q});
    seen = 1'b0;
    wake_in = 1'b0;
    repeat (3) @(negedge clk_sys) seen |= wake_detect_q;
    wake_in = 1'b1;
    check("short_wake_passed", 16'h0001, {15'h0000, seen});
  endtask : check_wake_filter
  // The host never programs phase segment 2 below two quanta in these settings.
  task automatic check_derived_short_bit;
    measure_bit(8'h00, 8'h00, 8'h07, 1'b1, 2, 10, 6);
  endtask : check_derived_short_bit
  // An edge four quanta into the bit may move the sample point by one jump width only.
  task automatic check_resync_bound;
    int n;
    measure_bit(8'h00, 8'h18, 8'h00, 1'b1, 2, 20, 12);
    @(negedge clk_sys) config_mode = 1'b0;
    wait_pulse(1, n);
    repeat (7) @(negedge clk_sys);
    drive_dominant = 1'b1;
    wait_pulse(2, n);
    check("resync_offset", 16'h0007, 16'(n));
    check("resync_bit", 16'h0000, {15'h0000, rx_bit_q});
    drive_dominant = 1'b0;
    @(negedge clk_sys) config_mode = 1'b1;
  endtask : check_resync_bound
  // A recessive spike over the last of three samples only must lose the vote.
  task automatic check_triple_vote;
    int n;
    measure_bit(8'h03, 8'h40, 8'h00, 1'b0, 8, 40, 24);
    @(negedge clk_sys) config_mode = 1'b0;
    wait_pulse(1, n);
    repeat (20) @(negedge clk_sys);
    drive_dominant = 1'b0;
    wait_pulse(2, n);
    check("vote_offset", 16'h0004, 16'(n));
    check("vote_majority", 16'h0000, {15'h0000, rx_bit_q});
    drive_dominant = 1'b1;
    @(negedge clk_sys) config_mode = 1'b1;
  endtask : check_triple_vote
  task automatic check_derived_long_phase;
    measure_bit(8'h01, 8'h62, 8'h00, 1'b0, 4, 56, 36);
  endtask : check_derived_long_phase
  task automatic check_own_phase_two;
    measure_bit(8'hC0, 8'hBF, 8'h07, 1'b1, 2, 50, 34);
  endtask : check_own_phase_two
  task automatic check_slowest_quantum;
    measure_bit(8'h3F, 8'h80, 8'h01, 1'b0, 128, 640, 384);
  endtask : check_slowest_quantum
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {resetn, reg_wr, drive_dominant, reg_addr, reg_wdata} = '0;
    {config_mode, wake_in} = 2'b11;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    check_register_access();
    check_wake_filter();
    check_derived_short_bit();
    check_resync_bound();
    check_derived_long_phase();
    check_triple_vote();
    check_own_phase_two();
    check_slowest_quantum();
    complete_run();
  end
  // The run needs under 5000 cycles, so 30000 leaves ample margin for slow settings.
  initial begin
    #300us;
    miscompares++;
    complete_run();
  end
endmodule : tb

// *** hdl/bit_timing_cfg_regs.sv ***
// The three bit-timing configuration registers and their read port.
// Assumes accesses are synchronous single-cycle strobes from the host port.
`include "can_bit_timing_defines.svh"

module bit_timing_cfg_regs (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       config_mode,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] quantum_jump_config,
  output logic      [7:0] segment_sampling_config,
  output logic      [7:0] phase_two_wake_config
);

  // ========================================================================
  // Decode
  logic [7:0] qj_q;
  logic [7:0] ss_q;
  logic [7:0] pw_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  wire        wr_ok  = reg_wr && config_mode;                          // [R13]
  wire        hit_qj = reg_addr == `QUANTUM_JUMP_CONFIG_ADDR;
  wire        hit_ss = reg_addr == `SEGMENT_SAMPLING_CONFIG_ADDR;
  wire        hit_pw = reg_addr == `PHASE_TWO_WAKE_CONFIG_ADDR;

  // Unmapped addresses read as zero; unimplemented bits never store.
  assign rdata_d = hit_qj ? qj_q : hit_ss ? ss_q : hit_pw ? pw_q : 8'h00;

  // ========================================================================
  // Storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      qj_q    <= `QUANTUM_JUMP_CONFIG_RST;
      ss_q    <= `SEGMENT_SAMPLING_CONFIG_RST;
      pw_q    <= `PHASE_TWO_WAKE_CONFIG_RST;
      rdata_q <= 8'h00;
    end else begin
      if (wr_ok && hit_qj) qj_q <= reg_wdata;
      if (wr_ok && hit_ss) ss_q <= reg_wdata;
      if (wr_ok && hit_pw) pw_q <= reg_wdata & `PHASE_TWO_WAKE_MASK;  // [R12]
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign quantum_jump_config     = qj_q;
  assign segment_sampling_config = ss_q;
  assign phase_two_wake_config   = pw_q;

  // ========================================================================
  // Checks
  property p_write_gate;
    @(posedge clk_sys) disable iff (!resetn)
    (reg_wr && !config_mode) |=> ($stable(qj_q) && $stable(ss_q) && $stable(pw_q));
  endproperty
  a_write_gate: assert property (p_write_gate) // [R13]
    else $error("Timing register changed outside configuration mode.");

  logic reg_rd_pw_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) reg_rd_pw_q <= 1'b0;
    else reg_rd_pw_q <= hit_pw;
  end
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!resetn)
    (reg_rd_pw_q) |-> (reg_rdata[7] == 1'b0 && reg_rdata[5:3] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R12]
    else $error("Unimplemented bits of the third timing register read nonzero.");

endmodule : bit_timing_cfg_regs

// *** hdl/can_bit_timing_config.sv ***
// CAN bit-timing engine with its configuration registers.
// Assumes all inputs are synchronous to clk_sys, which stands for the oscillator.
// Behaviour
// R1: With the phase-two source select set, phase segment 2 length comes from its own field.
// R2: With the select clear, the phase-two length field has no effect on the bit time.
// R3: With the select clear, phase segment 2 is the greater of phase segment 1 and two quanta.
// R4: The jump width field gives field plus one quanta and bounds every resync adjustment.
// R5: The time quantum lasts two times prescaler field plus one oscillator periods.
// R6: Triple-vote set takes the majority of three samples half a quantum apart, else one.
// R7: Phase segment 1 lasts its field plus one quanta.
// R8: The propagation segment lasts its field plus one quanta.
// R9: A phase-two length taken from its field lasts field plus one quanta.
// R10: Host software never programs phase segment 2 below two quanta.
// R11: The wake-up glitch filter is enabled exactly while the wake filter bit is one; the code follows the bit one clock later.
// R12: Bits 7 and 5:3 of the third timing register read zero and ignore writes.
// R13: Timing registers accept writes only in configuration mode.
// R14: A bit is sync, propagation, phase 1, phase 2, sampled at the end of phase 1.
`include "can_bit_timing_defines.svh"

module can_bit_timing_config (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       config_mode,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       bus_receive_pin,
  input  wire logic       wake_in,
  output logic            tq_tick_q,
  output logic            bit_start_q,
  output logic            sample_point_q,
  output logic            rx_bit_q,
  output logic            wake_filter_en_q,
  output logic            wake_detect_q
);

  // ========================================================================
  // Configuration registers
  logic [7:0] quantum_jump_config;
  logic [7:0] segment_sampling_config;
  logic [7:0] phase_two_wake_config;

  bit_timing_cfg_regs u_regs (
    .clk_sys                 (clk_sys),
    .resetn                  (resetn),
    .config_mode             (config_mode),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .quantum_jump_config     (quantum_jump_config),
    .segment_sampling_config (segment_sampling_config),
    .phase_two_wake_config   (phase_two_wake_config)
  );

  // ========================================================================
  // Field decode
  function automatic logic [3:0] field_len(input logic [2:0] f);
    field_len = {1'b0, f} + 4'h1;
  endfunction : field_len

  wire [5:0] quantum_prescaler       = quantum_jump_config[`PRESCALER_MSB:`PRESCALER_LSB];
  wire [1:0] resync_jump_width       = quantum_jump_config[`JUMP_WIDTH_MSB:`JUMP_WIDTH_LSB];
  wire [2:0] propagation_length      = segment_sampling_config[`PROP_LEN_MSB:`PROP_LEN_LSB];
  wire [2:0] phase_one_length        = segment_sampling_config[`PHASE_ONE_MSB:`PHASE_ONE_LSB];
  wire       triple_vote_select      = segment_sampling_config[`TRIPLE_VOTE_BIT];
  wire       phase_two_source_select = segment_sampling_config[`PHASE_TWO_SEL_BIT];
  wire [2:0] phase_two_length        = phase_two_wake_config[`PHASE_TWO_MSB:`PHASE_TWO_LSB];
  wire       wake_glitch_filter_enable = phase_two_wake_config[`WAKE_FILTER_BIT];

  wire [3:0] jump_len  = {2'b00, resync_jump_width} + 4'h1;                // [R4]
  wire [3:0] prop_len  = field_len(propagation_length);                    // [R8]
  wire [3:0] ph1_len   = field_len(phase_one_length);                      // [R7]
  wire [3:0] ph2_auto  = (ph1_len > `PROCESSING_TIME_TQ) ? ph1_len : `PROCESSING_TIME_TQ; // [R3]
  // The own-field length is never consulted unless the select bit asks for it.
  wire [3:0] ph2_len   = phase_two_source_select ? field_len(phase_two_length)  // [R1] [R9]
                                                 : ph2_auto;                     // [R2]
  wire [6:0] q_last    = {quantum_prescaler, 1'b1};                        // [R5]
  wire [6:0] q_half    = {1'b0, quantum_prescaler};

  // ========================================================================
  // Quantum prescaler
  // The engine is held while the registers are open, so a half-written
  // configuration never times a bit.
  wire        run = !config_mode;
  logic [6:0] qcnt_q;
  logic       restart;
  wire        tq_tick   = run && (qcnt_q == q_last);                       // [R5]
  wire        half_tick = run && (qcnt_q == q_half);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) qcnt_q <= 7'h00;
    else if (!run || tq_tick || restart) qcnt_q <= 7'h00;
    else qcnt_q <= qcnt_q + 7'h01;
  end

  // ========================================================================
  // Segment sequencer
  can_bit_timing_pkg::bit_segment_t seg_q;
  can_bit_timing_pkg::bit_segment_t seg_d;
  logic [3:0] tqc_q;
  logic [3:0] tqc_d;
  logic [3:0] ext_q;
  logic [3:0] trim_q;
  logic       synced_q;
  logic       rx_prev_q;
  logic       rx_bit_d;
  logic [1:0] samp_q;

  wire [3:0] ph1_end = ph1_len + ext_q;
  wire [3:0] ph2_end = ph2_len - trim_q;
  wire       sample_point = tq_tick && (seg_q == can_bit_timing_pkg::SEG_PHASE_ONE)
                            && (tqc_q == ph1_end - 4'h1);                 // [R14]

  // Resync only on a falling edge differing from the last sampled value.
  wire       fall   = run && rx_prev_q && !bus_receive_pin && !synced_q && (rx_bit_q == 1'b1);
  wire [3:0] e_pos  = (seg_q == can_bit_timing_pkg::SEG_PROP) ? tqc_q + 4'h1
                                                              : prop_len + tqc_q + 4'h1;
  wire       in_pos = (seg_q == can_bit_timing_pkg::SEG_PROP) ||
                      (seg_q == can_bit_timing_pkg::SEG_PHASE_ONE);
  wire       in_neg = seg_q == can_bit_timing_pkg::SEG_PHASE_TWO;
  wire [3:0] remain = ph2_end - tqc_q;
  assign restart = fall && in_neg && (remain <= jump_len);

  always_comb begin
    seg_d = seg_q;
    tqc_d = tqc_q;
    if (!run) begin
      seg_d = can_bit_timing_pkg::SEG_SYNC;
      tqc_d = 4'h0;
    end else if (restart) begin
      seg_d = can_bit_timing_pkg::SEG_SYNC;                                // [R4]
      tqc_d = 4'h0;
    end else if (tq_tick) begin
      tqc_d = tqc_q + 4'h1;
      unique case (seg_q)
        can_bit_timing_pkg::SEG_SYNC: begin
          seg_d = can_bit_timing_pkg::SEG_PROP;                            // [R14]
          tqc_d = 4'h0;
        end
        can_bit_timing_pkg::SEG_PROP: begin
          if (tqc_q == prop_len - 4'h1) begin                             // [R8]
            seg_d = can_bit_timing_pkg::SEG_PHASE_ONE;
            tqc_d = 4'h0;
          end
        end
        can_bit_timing_pkg::SEG_PHASE_ONE: begin
          if (sample_point) begin                                          // [R7]
            seg_d = can_bit_timing_pkg::SEG_PHASE_TWO;
            tqc_d = 4'h0;
          end
        end
        can_bit_timing_pkg::SEG_PHASE_TWO: begin
          if (tqc_q >= ph2_end - 4'h1) begin                              // [R1] [R3]
            seg_d = can_bit_timing_pkg::SEG_SYNC;
            tqc_d = 4'h0;
          end
        end
      endcase
    end
  end

  wire new_bit = run && (seg_d == can_bit_timing_pkg::SEG_SYNC) &&
                 ((seg_q != can_bit_timing_pkg::SEG_SYNC) || restart);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_q <= can_bit_timing_pkg::SEG_SYNC;
      tqc_q <= 4'h0;
    end else begin
      seg_q <= seg_d;
      tqc_q <= tqc_d;
    end
  end

  // ========================================================================
  // Resynchronization bookkeeping
  wire [3:0] ext_d = (e_pos < jump_len) ? e_pos : jump_len;                // [R4]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_q    <= 4'h0;
      trim_q   <= 4'h0;
      synced_q <= 1'b0;
    end else if (!run || new_bit) begin
      ext_q    <= 4'h0;
      trim_q   <= 4'h0;
      synced_q <= 1'b0;
    end else if (fall) begin
      synced_q <= 1'b1;
      if (in_pos) ext_q <= ext_d;                                          // [R4]
      if (in_neg && !restart) trim_q <= jump_len;                          // [R4]
    end
  end

  // ========================================================================
  // Bus sampling
  // Samples are kept every half quantum; the two most recent ones before
  // the sample point are exactly TQ and TQ/2 earlier.
  wire vote = (samp_q[1] & samp_q[0]) | (samp_q[1] & bus_receive_pin) |
              (samp_q[0] & bus_receive_pin);
  assign rx_bit_d = triple_vote_select ? vote : bus_receive_pin;           // [R6]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      samp_q    <= 2'b11;
      rx_prev_q <= 1'b1;
      rx_bit_q  <= 1'b1;
    end else begin
      rx_prev_q <= bus_receive_pin;
      if (half_tick || tq_tick) samp_q <= {samp_q[0], bus_receive_pin};   // [R6]
      if (sample_point) rx_bit_q <= rx_bit_d;                              // [R6]
    end
  end

  // ========================================================================
  // Wake-up glitch filter
  // A filtered wake needs the line low for the whole filter time; this
  // costs that much wake latency but rejects short spikes.
  localparam logic [7:0] WAKE_CYCLES = 8'(`WAKE_FILTER_CYCLES);
  logic [7:0] wcnt_q;
  wire        wake_low  = !wake_in;
  wire        wake_full = wcnt_q == WAKE_CYCLES;
  wire        wake_d    = wake_filter_en_q ? (wake_low && wake_full) : wake_low; // [R11]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wcnt_q           <= 8'h00;
      wake_filter_en_q <= 1'b0;
      wake_detect_q    <= 1'b0;
    end else begin
      wcnt_q           <= !wake_low ? 8'h00 : (wake_full ? wcnt_q : wcnt_q + 8'h01);
      wake_filter_en_q <= wake_glitch_filter_enable;                       // [R11]
      wake_detect_q    <= wake_d;
    end
  end

  // ========================================================================
  // Output strobes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tq_tick_q      <= 1'b0;
      bit_start_q    <= 1'b0;
      sample_point_q <= 1'b0;
    end else begin
      tq_tick_q      <= tq_tick;
      bit_start_q    <= new_bit;
      sample_point_q <= sample_point;                                      // [R14]
    end
  end

  // ========================================================================
  // Checks
  logic [6:0] gap_q;
  logic       gap_ok_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_q    <= 7'h00;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q    <= (!run || tq_tick || restart) ? 7'h00 : gap_q + 7'h01;
      gap_ok_q <= run && (gap_ok_q || tq_tick) && !restart;
    end
  end

  property p_tq_len;
    @(posedge clk_sys) disable iff (!resetn)
    (tq_tick && gap_ok_q) |-> (gap_q == {quantum_prescaler, 1'b1});
  endproperty
  a_tq_len: assert property (p_tq_len) // [R5]
    else $error("Time quantum length differs from two times prescaler plus one.");

  property p_ph2_own;
    @(posedge clk_sys) disable iff (!resetn)
    phase_two_source_select |-> (ph2_len == {1'b0, phase_two_length} + 4'h1);
  endproperty
  a_ph2_own: assert property (p_ph2_own) // [R1]
    else $error("Phase two length does not follow its own field.");

  property p_ph2_ignore;
    @(posedge clk_sys) disable iff (!resetn)
    (!phase_two_source_select && $stable(phase_one_length) && $stable(phase_two_source_select))
      |-> $stable(ph2_len);
  endproperty
  a_ph2_ignore: assert property (p_ph2_ignore) // [R2]
    else $error("Phase two length moved with its field while not selected.");

  property p_ph2_auto;
    @(posedge clk_sys) disable iff (!resetn)
    !phase_two_source_select |-> (ph2_len >= 4'h2 && ph2_len >= ph1_len &&
                                  (ph2_len == 4'h2 || ph2_len == ph1_len));
  endproperty
  a_ph2_auto: assert property (p_ph2_auto) // [R3]
    else $error("Automatic phase two length is not max of phase one and two.");

  property p_jump_bound;
    @(posedge clk_sys) disable iff (!resetn)
    (ext_q <= {2'b00, resync_jump_width} + 4'h1) && (trim_q <= {2'b00, resync_jump_width} + 4'h1);
  endproperty
  a_jump_bound: assert property (p_jump_bound) // [R4]
    else $error("Resync adjustment exceeds the jump width.");

  property p_single_sample;
    @(posedge clk_sys) disable iff (!resetn)
    (sample_point && !triple_vote_select) |=> (rx_bit_q == $past(bus_receive_pin));
  endproperty
  a_single_sample: assert property (p_single_sample) // [R6]
    else $error("Single sampling did not take the pin at the sample point.");

  property p_ph1_len;
    @(posedge clk_sys) disable iff (!resetn)
    sample_point |-> (tqc_q == {1'b0, phase_one_length} + ext_q);
  endproperty
  a_ph1_len: assert property (p_ph1_len) // [R7]
    else $error("Sample point not at end of phase one.");

  sequence s_prop_done;
    tq_tick && !restart && seg_q == can_bit_timing_pkg::SEG_PROP &&
      tqc_q == {1'b0, propagation_length};
  endsequence
  property p_prop_len;
    @(posedge clk_sys) disable iff (!resetn)
    s_prop_done |=> (seg_q == can_bit_timing_pkg::SEG_PHASE_ONE && tqc_q == 4'h0);
  endproperty
  a_prop_len: assert property (p_prop_len) // [R8]
    else $error("Propagation segment length wrong.");

  property p_wake_en;
    @(posedge clk_sys) disable iff (!resetn)
    ##1 wake_filter_en_q == $past(phase_two_wake_config[6]);
  endproperty
  a_wake_en: assert property (p_wake_en) // [R11]
    else $error("Wake filter enable does not follow its bit.");

  sequence s_sync_tick;
    tq_tick && !restart && seg_q == can_bit_timing_pkg::SEG_SYNC;
  endsequence
  property p_order;
    @(posedge clk_sys) disable iff (!resetn)
    s_sync_tick |=> (seg_q == can_bit_timing_pkg::SEG_PROP);
  endproperty
  a_order: assert property (p_order) // [R14]
    else $error("Sync quantum not followed by the propagation segment.");

endmodule : can_bit_timing_config

// *** pkg/can_bit_timing_defines.svh ***
// Register map, field positions, reset values and timing counts for the CAN
// bit-timing configuration block.
// Assumes a single 100 MHz system clock that also stands for the oscillator.
`ifndef CAN_BIT_TIMING_DEFINES_SVH
`define CAN_BIT_TIMING_DEFINES_SVH

// ==========================================================================
// Register offsets
`define PHASE_TWO_WAKE_CONFIG_ADDR   8'h28
`define SEGMENT_SAMPLING_CONFIG_ADDR 8'h29
`define QUANTUM_JUMP_CONFIG_ADDR     8'h2A

// ==========================================================================
// Reset values
`define PHASE_TWO_WAKE_CONFIG_RST    8'h00
`define SEGMENT_SAMPLING_CONFIG_RST  8'h00
`define QUANTUM_JUMP_CONFIG_RST      8'h00

// ==========================================================================
// Field positions
`define PRESCALER_MSB   5
`define PRESCALER_LSB   0
`define JUMP_WIDTH_MSB  7
`define JUMP_WIDTH_LSB  6
`define PROP_LEN_MSB    2
`define PROP_LEN_LSB    0
`define PHASE_ONE_MSB   5
`define PHASE_ONE_LSB   3
`define TRIPLE_VOTE_BIT 6
`define PHASE_TWO_SEL_BIT 7
`define PHASE_TWO_MSB   2
`define PHASE_TWO_LSB   0
`define WAKE_FILTER_BIT 6
`define PHASE_TWO_WAKE_MASK 8'h47

// ==========================================================================
// Timing
`define PROCESSING_TIME_TQ 4'h2
`define CLK_PERIOD_NS      10
`define WAKE_FILTER_NS     100
`define WAKE_FILTER_CYCLES ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** pkg/can_bit_timing_pkg.sv ***
// Types shared by the bit-timing configuration design files.
// Assumes the constants header is compiled alongside.
package can_bit_timing_pkg;

  // ========================================================================
  // Bit segment sequence
  typedef enum logic [1:0] {
    SEG_SYNC,
    SEG_PROP,
    SEG_PHASE_ONE,
    SEG_PHASE_TWO
  } bit_segment_t;

endpackage : can_bit_timing_pkg
